//--- common/bri_pkg.sv
package bri_pkg;
   localparam int CLK_HZ = 100_000_000;
   // reset inhibit time after a division's own actuation
   localparam int RESET_DELAY_S = 25;
   localparam longint RESET_DELAY_CYC_L = longint'(RESET_DELAY_S) * longint'(CLK_HZ);
   localparam int TMR_W = 32;
   localparam logic [TMR_W-1:0] RESET_DELAY_CYC = RESET_DELAY_CYC_L[TMR_W-1:0];
   // spacing between successive discharge volume valve reopen commands
   localparam int VALVE_STEP_MS = 2000;
   localparam longint VALVE_STEP_CYC_L = longint'(VALVE_STEP_MS) * longint'(CLK_HZ) / 64'h0000_0000_0000_03E8;
   localparam logic [TMR_W-1:0] VALVE_STEP_CYC = VALVE_STEP_CYC_L[TMR_W-1:0];
   localparam int NUM_DV_VALVES = 4;
   localparam logic [NUM_DV_VALVES-1:0] DV_OPEN_RST = 4'hF;
   localparam logic [TMR_W-1:0] TMR_ZERO = 32'h0000_0000;
   localparam logic [1:0] SYNC_RST = 2'h0;
   typedef enum logic [1:0] {
      BRI_SEQ_IDLE = 2'b00,
      BRI_SEQ_STEP = 2'b01,
      BRI_SEQ_WAIT = 2'b11
   } bri_seq_type;
endpackage : bri_pkg

//--- core/bri_trip_logic.sv
`timescale 1ns/1ps
`default_nettype none
module bri_trip_logic #(
   parameter logic [31:0] RESET_DELAY_CYC_P = bri_pkg::RESET_DELAY_CYC,
   parameter logic [31:0] VALVE_STEP_CYC_P = bri_pkg::VALVE_STEP_CYC
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   // process switches: bit0 = channel A/B, bit1 = channel C/D
   input wire logic [1:0] div1_low_level_in,
   input wire logic [1:0] div1_high_press_in,
   input wire logic [1:0] div2_low_level_in,
   input wire logic [1:0] div2_high_press_in,
   // operator panel, bit0 = division 1, bit1 = division 2
   input wire logic [1:0] manual_armed_in,
   input wire logic [1:0] manual_pressed_in,
   input wire logic [1:0] reset_push_in,
   input wire logic [1:0] alarm_ack_in,
   // local keylocked switches and status
   input wire logic [1:0] maint_bypass_in,
   input wire logic [1:0] pump_bypass_in,
   input wire logic [1:0] div_fault_in,
   // valve position feedback: bit0 vent, bit1 block
   input wire logic [1:0] div1_valve_pos_in,
   input wire logic [1:0] div2_valve_pos_in,
   // solenoid drivers, bit0 vent, bit1 block
   output logic [1:0] div1_solenoid_out,
   output logic [1:0] div2_solenoid_out,
   output logic [1:0] pump_trip_out,
   output logic [bri_pkg::NUM_DV_VALVES-1:0] dv_valve_open_out,
   // annunciators
   output logic [1:0] actuated_alarm_out,
   output logic [1:0] armed_alarm_out,
   output logic [1:0] bypass_alarm_out,
   output logic [1:0] pump_bypass_alarm_out,
   output logic inoperable_out,
   // recorders
   output logic scram_out,
   output logic [1:0] div_trip_out,
   output logic trip_event_out,
   output logic recorder_trigger_out
);
   import bri_pkg::*;

   // all outside inputs pass three flip-flops; a change counts once stages 2 and 3 agree
   localparam int NIN = 22;
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] sync1;
   logic [NIN-1:0] sync2;
   logic [NIN-1:0] sync3;
   logic [NIN-1:0] filt;
   logic [NIN-1:0] next_filt;

   assign raw_in = {div_fault_in, pump_bypass_in, maint_bypass_in, alarm_ack_in, reset_push_in, manual_pressed_in,
                    manual_armed_in, div2_high_press_in, div2_low_level_in, div1_high_press_in, div1_low_level_in};

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign next_filt = (sync2 & sync3) | (filt & (sync2 | sync3));

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         filt <= '0;
      end else begin
         filt <= next_filt;
      end
   end

   // filtered inputs, named by purpose
   wire [1:0] d1_low = filt[1:0];
   wire [1:0] d1_hp = filt[3:2];
   wire [1:0] d2_low = filt[5:4];
   wire [1:0] d2_hp = filt[7:6];
   wire [1:0] m_armed = filt[9:8];
   wire [1:0] m_press = filt[11:10];
   wire [1:0] rst_push = filt[13:12];
   wire [1:0] ack = filt[15:14];
   wire [1:0] byp = filt[17:16];
   wire [1:0] pbyp = filt[19:18];
   wire [1:0] fault = filt[21:20];
   // shared down-counter step for the reset timers and the valve spacing
   function automatic logic [TMR_W-1:0] count_down(input logic [TMR_W-1:0] v);
      return v - 32'h0000_0001;
   endfunction : count_down

   // division 1 sees channels A and C only, division 2 B and D
   function automatic logic two_of_two(input logic [1:0] ch);
      return ch[0] & ch[1];
   endfunction : two_of_two

   wire [1:0] manual_req = m_armed & m_press;
   wire [1:0] auto_trip = {two_of_two(d2_low) | two_of_two(d2_hp),
                           two_of_two(d1_low) | two_of_two(d1_hp)};
   // the maintenance bypass is the only inhibit; nothing bypasses during operation
   wire [1:0] init_trip = (auto_trip | manual_req) & ~byp;

   logic [1:0] sealed;
   logic [TMR_W-1:0] tmr [2];
   // a timer at zero means the reset inhibit has run out
   wire [1:0] tmr_done = {tmr[1] == TMR_ZERO, tmr[0] == TMR_ZERO};
   wire both_done = tmr_done[0] & tmr_done[1];
   wire both_tripped = sealed[0] & sealed[1];
   // with both divisions tripped a reset needs both timers run out
   wire [1:0] reset_ok = both_tripped ? {2{both_done}} : tmr_done;
   wire [1:0] reset_take = rst_push & sealed & reset_ok & ~init_trip;
   logic [1:0] sealed_d;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_div
         always_ff @(posedge clk_sys_in) begin
            if (!nrst_in) begin
               sealed[g] <= 1'b0;
               tmr[g] <= TMR_ZERO;
            // loading only on a fresh trip keeps a held input from restarting the delay
            end else if (init_trip[g] && !sealed[g]) begin
               sealed[g] <= 1'b1;
               tmr[g] <= RESET_DELAY_CYC_P;
            end else if (reset_take[g]) begin
               sealed[g] <= 1'b0;
            end else if (sealed[g] && !tmr_done[g]) begin
               tmr[g] <= count_down(tmr[g]);
            end
         end
      end
   endgenerate

   // reset reopens discharge volume valves one by one, avoiding water hammer
   bri_seq_type seq;
   logic [TMR_W-1:0] step_cnt;
   logic [1:0] step_idx;
   logic [NUM_DV_VALVES-1:0] dv_open;
   wire scram_now = both_tripped;
   wire any_reset = |(sealed_d & ~sealed);
   wire seq_start = (dv_open != DV_OPEN_RST) && any_reset;
   wire step_last = (step_idx == 2'h3);
   wire step_zero = (step_cnt == TMR_ZERO);

   // a scram closes everything at once; only the reopening is paced
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         seq <= BRI_SEQ_IDLE;
      end else if (scram_now) begin
         seq <= BRI_SEQ_IDLE;
      end else begin
         case (seq)
            BRI_SEQ_IDLE: begin
               if (seq_start) begin
                  seq <= BRI_SEQ_STEP;
               end
            end
            BRI_SEQ_STEP: begin
               seq <= step_last ? BRI_SEQ_IDLE : BRI_SEQ_WAIT;
            end
            BRI_SEQ_WAIT: begin
               if (step_zero) begin
                  seq <= BRI_SEQ_STEP;
               end
            end
            default: begin
               seq <= BRI_SEQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         step_idx <= 2'h0;
      end else if (seq == BRI_SEQ_IDLE) begin
         step_idx <= 2'h0;
      end else if (seq == BRI_SEQ_WAIT && step_zero) begin
         step_idx <= step_idx + 2'h1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         step_cnt <= TMR_ZERO;
      end else if (seq == BRI_SEQ_STEP) begin
         step_cnt <= VALVE_STEP_CYC_P;
      end else if (seq == BRI_SEQ_WAIT && !step_zero) begin
         step_cnt <= count_down(step_cnt);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         dv_open <= DV_OPEN_RST;
      end else if (scram_now) begin
         dv_open <= '0;
      end else if (seq == BRI_SEQ_STEP) begin
         dv_open[step_idx] <= 1'b1;
      end
   end

   // actuation alarm latches on valve feedback; ack refused while feedback remains
   // switches pass their own three-stage filter, then two settling registers
   logic [1:0] act_alarm;
   logic [3:0] pos_s1;
   logic [3:0] pos_s2;
   logic [3:0] pos_s3;
   logic [3:0] pos_filt;
   logic [1:0] div1_pos_f;
   logic [1:0] div2_pos_f;
   logic [1:0] pos1_f;
   logic [1:0] pos2_f;
   wire [1:0] valves_on = {&pos2_f, &pos1_f};

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         pos1_f <= 2'h0;
         pos2_f <= 2'h0;
      end else begin
         pos1_f <= div1_pos_f;
         pos2_f <= div2_pos_f;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         div1_pos_f <= 2'h0;
         div2_pos_f <= 2'h0;
      end else begin
         div1_pos_f <= pos_filt[1:0];
         div2_pos_f <= pos_filt[3:2];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         pos_s1 <= 4'h0;
         pos_s2 <= 4'h0;
         pos_s3 <= 4'h0;
         pos_filt <= 4'h0;
      end else begin
         pos_s1 <= {div2_valve_pos_in, div1_valve_pos_in};
         pos_s2 <= pos_s1;
         pos_s3 <= pos_s2;
         pos_filt <= (pos_s2 & pos_s3) | (pos_filt & (pos_s2 | pos_s3));
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         act_alarm <= 2'h0;
      end else begin
         // set wins over the ack; ack only lands once feedback is gone
         act_alarm <= valves_on | (act_alarm & ~ack);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         sealed_d <= 2'h0;
      end else begin
         sealed_d <= sealed;
      end
   end

   // solenoid and valve drivers
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         div1_solenoid_out <= 2'h0;
         div2_solenoid_out <= 2'h0;
         pump_trip_out <= 2'h0;
         dv_valve_open_out <= DV_OPEN_RST;
      end else begin
         div1_solenoid_out <= {2{sealed[0]}};
         div2_solenoid_out <= {2{sealed[1]}};
         pump_trip_out <= (auto_trip | manual_req) & ~pbyp;
         dv_valve_open_out <= dv_open;
      end
   end

   // annunciators
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         actuated_alarm_out <= 2'h0;
         armed_alarm_out <= 2'h0;
         bypass_alarm_out <= 2'h0;
         pump_bypass_alarm_out <= 2'h0;
         inoperable_out <= 1'b0;
      end else begin
         actuated_alarm_out <= act_alarm;
         armed_alarm_out <= m_armed;
         bypass_alarm_out <= byp;
         pump_bypass_alarm_out <= pbyp;
         inoperable_out <= |(byp | fault);
      end
   end

   // recorders; a new trip is a rising seal-in, one pulse shared by divisions that seal in on the same cycle
   wire [1:0] new_trip = sealed & ~sealed_d;
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         scram_out <= 1'b0;
         div_trip_out <= 2'h0;
         trip_event_out <= 1'b0;
         recorder_trigger_out <= 1'b0;
      end else begin
         scram_out <= scram_now;
         div_trip_out <= sealed;
         trip_event_out <= |new_trip;
         recorder_trigger_out <= scram_now;
      end
   end
endmodule : bri_trip_logic
`default_nettype wire

//--- verification/bri_valve_model.sv
`timescale 1ns/1ps
`default_nettype none
module bri_valve_model (
   // clock
   input wire logic clk_sys_in,
   // coil drive from the trip logic
   input wire logic [1:0] div1_solenoid_in,
   input wire logic [1:0] div2_solenoid_in,
   // position switches
   output logic [1:0] div1_valve_pos_out,
   output logic [1:0] div2_valve_pos_out
);
   logic [3:0] stroke [0:2];
   // valves need travel time, so position lags the coils by three cycles
   always_ff @(posedge clk_sys_in) begin
      stroke[0] <= {div2_solenoid_in, div1_solenoid_in};
      stroke[1] <= stroke[0];
      stroke[2] <= stroke[1];
   end
   assign {div2_valve_pos_out, div1_valve_pos_out} = stroke[2];
endmodule : bri_valve_model
`default_nettype wire

//--- verification/bri_trip_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bri_trip_checker #(
   parameter logic [31:0] RESET_DELAY_CYC_P = 32'h0000_0064
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   // watched inputs
   input wire logic [1:0] div1_low_level_in,
   input wire logic [1:0] reset_push_in,
   input wire logic [1:0] maint_bypass_in,
   input wire logic [1:0] pump_bypass_in,
   input wire logic [1:0] div_fault_in,
   // watched outputs
   input wire logic [1:0] div1_solenoid_out,
   input wire logic [1:0] pump_trip_out,
   input wire logic [3:0] dv_valve_open_out,
   input wire logic [1:0] bypass_alarm_out,
   input wire logic inoperable_out,
   input wire logic scram_out,
   input wire logic [1:0] div_trip_out,
   input wire logic trip_event_out,
   input wire logic recorder_trigger_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   logic [31:0] held;
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in || !div_trip_out[0]) held <= 32'h0000_0000;
      else held <= held + 32'h0000_0001;
   end
   AST_TRIP: assert property ((&div1_low_level_in && !maint_bypass_in[0] && !div_fault_in[0]) [*8]
      |-> div_trip_out[0]) else $error("division one did not trip");
   AST_SCRAM: assert property (!(&div_trip_out) [*2] |-> !scram_out) else $error("scram without both");
   AST_SOL: assert property (div1_solenoid_out == {2{div_trip_out[0]}}) else $error("solenoid mismatch");
   AST_SEAL: assert property (!reset_push_in[0] [*8] ##0 div_trip_out[0] |=> div_trip_out[0])
      else $error("seal lost without reset");
   AST_DELAY: assert property ($fell(div_trip_out[0]) |-> held >= RESET_DELAY_CYC_P - 32'h0000_0001)
      else $error("reset accepted early");
   AST_BYP: assert property (maint_bypass_in[0] [*8] |-> bypass_alarm_out[0] && inoperable_out
      && !$rose(div_trip_out[0])) else $error("bypass not honoured");
   AST_PUMP: assert property (pump_bypass_in[1] [*8] |-> !pump_trip_out[1]) else $error("pump trip");
   AST_EVENT: assert property ($rose(div_trip_out[0]) |-> trip_event_out) else $error("no event");
   AST_REC: assert property ($rose(scram_out) |-> ##[0:2] recorder_trigger_out) else $error("no trigger");
   AST_ORDER: assert property ($rose(dv_valve_open_out[3]) |-> &dv_valve_open_out[2:0])
      else $error("valve order");
   cover property ($rose(scram_out));
   cover property ($fell(div_trip_out[0]));
   cover property ($rose(dv_valve_open_out[3]));
endmodule : bri_trip_checker
bind bri_trip_logic bri_trip_checker #(.RESET_DELAY_CYC_P(RESET_DELAY_CYC_P)) chk_u (.*);
`default_nettype wire

//--- verification/bri_trip_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bri_trip_logic_bench;
   logic clk_sys_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [1:0] div1_low_level_in = 2'h0, div1_high_press_in = 2'h0, div2_low_level_in = 2'h0;
   logic [1:0] div2_high_press_in = 2'h0, manual_armed_in = 2'h0, manual_pressed_in = 2'h0;
   logic [1:0] reset_push_in = 2'h0, alarm_ack_in = 2'h0, maint_bypass_in = 2'h0;
   logic [1:0] pump_bypass_in = 2'h0, div_fault_in = 2'h0, div1_valve_pos_in, div2_valve_pos_in;
   logic [1:0] div1_solenoid_out, div2_solenoid_out, pump_trip_out, actuated_alarm_out;
   logic [1:0] armed_alarm_out, bypass_alarm_out, pump_bypass_alarm_out, div_trip_out;
   logic [3:0] dv_valve_open_out;
   logic inoperable_out, scram_out, trip_event_out, recorder_trigger_out;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   // short counts keep the run under a thousand cycles
   bri_trip_logic #(.RESET_DELAY_CYC_P(32'h0000_0064), .VALVE_STEP_CYC_P(32'h0000_000A)) dut_u (.*);
   bri_valve_model valves_u (.clk_sys_in(clk_sys_in), .div1_solenoid_in(div1_solenoid_out),
      .div2_solenoid_in(div2_solenoid_out), .div1_valve_pos_out(div1_valve_pos_in),
      .div2_valve_pos_out(div2_valve_pos_in));
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         summarize();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : wt
   task automatic sw(input int n);
      wt(n);
      #2;
   endtask : sw
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic push(input logic [1:0] m);
      wt(1);
      reset_push_in <= m;
      wt(8);
      reset_push_in <= 2'h0;
   endtask : push
   task automatic t_auto;
      wt(1);
      div1_low_level_in <= 2'h3;
      div2_low_level_in <= 2'h1;
      sw(10);
      chk("div_trip", 8'h01, div_trip_out);
      chk("pump_trip", 8'h01, pump_trip_out);
      wt(1);
      div1_low_level_in <= 2'h0;
      div2_high_press_in <= 2'h3;
      sw(10);
      chk("div_trip", 8'h03, div_trip_out);
      chk("scram", 8'h01, scram_out);
      chk("solenoids", 8'h33, {2'h0, div2_solenoid_out, 2'h0, div1_solenoid_out});
      chk("recorder", 8'h01, recorder_trigger_out);
      chk("dv_valves", 8'h00, dv_valve_open_out);
      wt(1);
      div2_high_press_in <= 2'h0;
      div2_low_level_in <= 2'h0;
      alarm_ack_in <= 2'h3;
      sw(20);
      chk("actuated", 8'h03, actuated_alarm_out);
      wt(1);
      alarm_ack_in <= 2'h0;
      wt(50);
      push(2'h3);
      sw(6);
      chk("div_trip", 8'h03, div_trip_out);
      wt(20);
      push(2'h3);
      sw(6);
      chk("div_trip", 8'h00, div_trip_out);
      sw(60);
      chk("dv_valves", 8'h0F, dv_valve_open_out);
      wt(1);
      alarm_ack_in <= 2'h3;
      sw(8);
      chk("actuated", 8'h00, actuated_alarm_out);
      wt(1);
      alarm_ack_in <= 2'h0;
      $display("test auto done");
   endtask : t_auto
   task automatic t_manual;
      wt(1);
      manual_armed_in <= 2'h2;
      sw(10);
      chk("armed", 8'h02, armed_alarm_out);
      wt(1);
      manual_armed_in <= 2'h0;
      manual_pressed_in <= 2'h2;
      sw(10);
      chk("div_trip", 8'h00, div_trip_out);
      wt(1);
      manual_armed_in <= 2'h2;
      sw(10);
      chk("half", 8'h02, {scram_out, div_trip_out});
      wt(1);
      manual_armed_in <= 2'h0;
      manual_pressed_in <= 2'h0;
      push(2'h2);
      sw(6);
      chk("div_trip", 8'h02, div_trip_out);
      wt(100);
      push(2'h2);
      sw(70);
      chk("div_trip", 8'h00, div_trip_out);
      $display("test manual done");
   endtask : t_manual
   task automatic t_bypass;
      wt(1);
      maint_bypass_in <= 2'h1;
      pump_bypass_in <= 2'h2;
      div1_low_level_in <= 2'h3;
      div2_high_press_in <= 2'h3;
      sw(10);
      chk("alarms", 8'h19, {bypass_alarm_out, pump_bypass_alarm_out, 1'b0, inoperable_out});
      chk("div_trip", 8'h02, {pump_trip_out[1], div_trip_out});
      wt(1);
      maint_bypass_in <= 2'h0;
      pump_bypass_in <= 2'h0;
      div1_low_level_in <= 2'h0;
      div2_high_press_in <= 2'h0;
      div_fault_in <= 2'h2;
      sw(10);
      chk("inoperable", 8'h01, inoperable_out);
      wt(1);
      div_fault_in <= 2'h0;
      wt(100);
      push(2'h2);
      sw(70);
      chk("idle", 8'h00, {bypass_alarm_out, inoperable_out, div_trip_out});
      $display("test bypass done");
   endtask : t_bypass
   initial begin
      wt(16);
      nrst_in <= 1'b1;
      t_auto();
      t_manual();
      t_bypass();
      summarize();
   end
endmodule : bri_trip_logic_bench
`default_nettype wire
